//--- logic/sca_top.sv
`timescale 1ns/10ps
module sca_top
   import sca_pkg::*;
#(
   parameter int AUTO_CYC = SCA_AUTO_CYC
) (
   input wire logic clock,
   input wire logic nrst,
   input wire logic [3:0][13:0] sig_i,
   input wire logic [3:0][13:0] sig_q,
   input wire logic sig_valid,
   input wire logic sig_loss,
   input wire logic [3:0] low_frequency_input_path,
   input wire logic [1:0] chan_select,
   input wire logic [2:0] chan_active,
   input wire logic run,
   input wire logic single_cmd,
   input wire logic trig_enable,
   input wire logic trig_pin,
   input wire logic len_is_duration,
   input wire logic [16:0] len_samples,
   input wire logic [12:0] dur_units,
   input wire logic seg_enable,
   input wire logic [10:0] seg_count,
   input wire logic hw_avg_enable,
   input wire logic [16:0] avg_count,
   input wire logic ema_enable,
   input wire logic [15:0] ema_count,
   input wire logic ema_reset,
   input wire logic out_ready,
   output logic out_valid,
   output logic [13:0] out_i,
   output logic [13:0] out_q,
   output logic out_last,
   output logic busy,
   output logic shot_captured,
   output logic shot_invalid,
   output logic config_error
);
   // No reset on the sample stores; contents are only read after being written
   logic [27:0] shot_buf [SCA_MEM_WORDS];
   logic [61:0] sum_mem [SCA_MEM_WORDS];
   logic [27:0] ema_mem [SCA_MEM_WORDS];

   sca_state_type state_reg;
   logic [16:0] idx_reg;
   logic [16:0] base_reg;
   logic [16:0] rd_reg;
   logic [16:0] len_reg;
   logic [16:0] total_reg;
   logic [10:0] segs_reg;
   logic [10:0] seg_idx_reg;
   logic [16:0] avgn_reg;
   logic [16:0] avg_idx_reg;
   logic single_reg;
   logic lost_reg;
   logic ema_fresh_reg;
   logic [13:0] res_i_reg;
   logic [13:0] res_q_reg;
   logic div_start_reg;
   logic [31:0] auto_cnt_reg;
   logic trig_s1_reg;
   logic trig_s2_reg;
   logic trig_s3_reg;
   logic busy_reg;
   logic captured_reg;
   logic invalid_reg;
   logic cfg_err_reg;

   // Input selection and sample shaping
   wire [13:0] sel_i = sig_i[chan_select];
   wire [13:0] sel_q = low_frequency_input_path[chan_select] ? 14'h0000 :
                       sig_q[chan_select];
   wire [27:0] sample = {sel_i, sel_q};

   // Length, segment and capacity decode
   wire [16:0] dur_len = 17'(32'(dur_units) * SCA_SA_PER_RES);
   wire [16:0] raw_len = len_is_duration ? dur_len : len_samples;
   wire [16:0] step_len = raw_len & SCA_LEN_MASK;
   wire [16:0] eff_len = (step_len < SCA_LEN_MIN) ? SCA_LEN_MIN : step_len;
   wire [16:0] cap = (chan_active <= 3'h1) ? SCA_CAP_1 :
                     (chan_active == 3'h2) ? SCA_CAP_2 : SCA_CAP_4;
   wire [10:0] segs = (!seg_enable || seg_count == 11'h000) ? 11'h001 :
                      (seg_count > SCA_SEG_MAX) ? SCA_SEG_MAX : seg_count;
   wire [10:0] segs_go = single_cmd ? 11'h001 : segs;
   wire [27:0] need = 28'(eff_len) * 28'(segs_go);
   wire cfg_bad = need > 28'(cap);
   wire [16:0] avgn = (!hw_avg_enable || avg_count == 17'h00000) ? 17'h00001 :
                      (avg_count > SCA_AVG_MAX) ? SCA_AVG_MAX : avg_count;
   wire [16:0] ema_n = (ema_count == 16'h0000) ? 17'h00001 : {1'b0, ema_count};
   wire start_any = single_cmd | run;

   // Trigger generation
   wire trig_edge = trig_s2_reg & !trig_s3_reg;
   wire auto_tick = auto_cnt_reg == 32'(AUTO_CYC - 1);
   wire fire = trig_enable ? trig_edge : auto_tick;

   // Capture and accumulate addressing
   wire cap_take = (state_reg == SCA_CAPT) && sig_valid;
   wire idx_end = idx_reg == len_reg - 17'h00001;
   wire lost_now = lost_reg | sig_loss;
   wire [15:0] acc_addr = 16'(base_reg + idx_reg);
   wire [27:0] shot_word = shot_buf[idx_reg[15:0]];
   wire [61:0] sum_old = sum_mem[acc_addr];
   wire first_set = avg_idx_reg == 17'h00000;
   wire [30:0] add_i = 31'($signed(shot_word[27:14]));
   wire [30:0] add_q = 31'($signed(shot_word[13:0]));
   // 31-bit sums hold 65536 full-scale 14-bit samples without wrap
   wire [30:0] acc_i = (first_set ? 31'h0 : sum_old[61:31]) + add_i;
   wire [30:0] acc_q = (first_set ? 31'h0 : sum_old[30:0]) + add_q;
   wire seg_more = seg_idx_reg + 11'h001 < segs_reg;
   wire avg_more = avg_idx_reg + 17'h00001 < avgn_reg;

   // Readout datapath
   wire [61:0] sum_rd = sum_mem[rd_reg[15:0]];
   wire [27:0] ema_old = ema_mem[rd_reg[15:0]];
   wire rd_last = rd_reg == total_reg - 17'h00001;
   wire signed [14:0] dif_i = $signed({res_i_reg[13], res_i_reg}) -
                              $signed({ema_old[27], ema_old[27:14]});
   wire signed [14:0] dif_q = $signed({res_q_reg[13], res_q_reg}) -
                              $signed({ema_old[13], ema_old[13:0]});
   wire in_ema = state_reg == SCA_REMA;
   wire [30:0] num_i = in_ema ? 31'(dif_i) : sum_rd[61:31];
   wire [30:0] num_q = in_ema ? 31'(dif_q) : sum_rd[30:0];
   wire [16:0] den = in_ema ? ema_n : avgn_reg;
   wire [30:0] quo_i;
   wire [30:0] quo_q;
   wire div_done_i;
   wire div_done_q;
   wire [13:0] ema_i = ema_old[27:14] + quo_i[13:0];
   wire [13:0] ema_q = ema_old[13:0] + quo_q[13:0];
   wire fifo_ready;
   wire emit_go = (state_reg == SCA_EMIT) && fifo_ready;
   wire ema_first = ema_enable && ema_fresh_reg;
   wire ema_clear = emit_go && rd_last && ema_enable;

   sca_div #(.NW(SCA_SUM_W), .DW(17)) u_div_i (
      .clock(clock),
      .nrst(nrst),
      .start(div_start_reg),
      .num(num_i),
      .den(den),
      .quo(quo_i),
      .done(div_done_i)
   );

   sca_div #(.NW(SCA_SUM_W), .DW(17)) u_div_q (
      .clock(clock),
      .nrst(nrst),
      .start(div_start_reg),
      .num(num_q),
      .den(den),
      .quo(quo_q),
      .done(div_done_q)
   );

   // Output buffer lets a slow reader stall the readout instead of losing words
   sca_fifo #(.WIDTH(SCA_FIFO_W), .DEPTH(SCA_FIFO_DEPTH)) u_fifo (
      .clock(clock),
      .nrst(nrst),
      .s_valid(state_reg == SCA_EMIT),
      .s_ready(fifo_ready),
      .s_data({rd_last, res_i_reg, res_q_reg}),
      .m_valid(out_valid),
      .m_ready(out_ready),
      .m_data({out_last, out_i, out_q})
   );

   assign busy = busy_reg;
   assign shot_captured = captured_reg;
   assign shot_invalid = invalid_reg;
   assign config_error = cfg_err_reg;

   always_ff @(posedge clock) begin
      if (cap_take) begin
         shot_buf[idx_reg[15:0]] <= sample;
      end
      if (state_reg == SCA_ACCUM) begin
         sum_mem[acc_addr] <= {acc_i, acc_q};
      end
      if (state_reg == SCA_RDIV && div_done_i && ema_first) begin
         ema_mem[rd_reg[15:0]] <= {quo_i[13:0], quo_q[13:0]};
      end else if (in_ema && div_done_i) begin
         ema_mem[rd_reg[15:0]] <= {ema_i, ema_q};
      end
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         trig_s1_reg <= 1'b0;
         trig_s2_reg <= 1'b0;
         trig_s3_reg <= 1'b0;
         auto_cnt_reg <= '0;
         busy_reg <= 1'b0;
         ema_fresh_reg <= 1'b1;
      end else begin
         trig_s1_reg <= trig_pin;
         trig_s2_reg <= trig_s1_reg;
         trig_s3_reg <= trig_s2_reg;
         auto_cnt_reg <= (state_reg == SCA_IDLE || auto_tick) ? '0 :
                         auto_cnt_reg + 32'h1;
         busy_reg <= state_reg != SCA_IDLE;
         // A reset request in the same cycle as the clear still wins
         ema_fresh_reg <= ema_reset | (ema_fresh_reg & !ema_clear);
      end
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         state_reg <= SCA_IDLE;
         idx_reg <= '0;
         base_reg <= '0;
         rd_reg <= '0;
         len_reg <= SCA_LEN_MIN;
         total_reg <= SCA_LEN_MIN;
         segs_reg <= 11'h001;
         seg_idx_reg <= '0;
         avgn_reg <= 17'h00001;
         avg_idx_reg <= '0;
         single_reg <= 1'b0;
         lost_reg <= 1'b0;
         res_i_reg <= '0;
         res_q_reg <= '0;
         div_start_reg <= 1'b0;
         captured_reg <= 1'b0;
         invalid_reg <= 1'b0;
         cfg_err_reg <= 1'b0;
      end else begin
         div_start_reg <= 1'b0;
         captured_reg <= 1'b0;
         invalid_reg <= 1'b0;
         case (state_reg)
            SCA_IDLE: begin
               if (start_any) begin
                  cfg_err_reg <= cfg_bad;
               end
               if (start_any && !cfg_bad) begin
                  single_reg <= single_cmd;
                  len_reg <= eff_len;
                  segs_reg <= segs_go;
                  total_reg <= need[16:0];
                  avgn_reg <= single_cmd ? 17'h00001 : avgn;
                  seg_idx_reg <= '0;
                  avg_idx_reg <= '0;
                  base_reg <= '0;
                  state_reg <= SCA_ARM;
               end
            end
            SCA_ARM: begin
               idx_reg <= '0;
               lost_reg <= 1'b0;
               if (!single_reg && !run) begin
                  state_reg <= SCA_IDLE;
               end else if (fire) begin
                  state_reg <= SCA_CAPT;
               end
            end
            SCA_CAPT: begin
               lost_reg <= lost_now;
               if (cap_take) begin
                  idx_reg <= idx_reg + 17'h00001;
               end
               if (cap_take && idx_end) begin
                  idx_reg <= '0;
                  // A damaged shot never touches the sums
                  invalid_reg <= lost_now;
                  state_reg <= lost_now ? SCA_ARM : SCA_ACCUM;
               end
            end
            SCA_ACCUM: begin
               idx_reg <= idx_reg + 17'h00001;
               if (idx_end) begin
                  state_reg <= SCA_NEXT;
               end
            end
            SCA_NEXT: begin
               captured_reg <= 1'b1;
               rd_reg <= '0;
               if (seg_more) begin
                  seg_idx_reg <= seg_idx_reg + 11'h001;
                  base_reg <= base_reg + len_reg;
                  state_reg <= SCA_ARM;
               end else if (avg_more) begin
                  seg_idx_reg <= '0;
                  base_reg <= '0;
                  avg_idx_reg <= avg_idx_reg + 17'h00001;
                  state_reg <= SCA_ARM;
               end else begin
                  div_start_reg <= 1'b1;
                  state_reg <= SCA_RDIV;
               end
            end
            SCA_RDIV: begin
               if (div_done_i) begin
                  res_i_reg <= quo_i[13:0];
                  res_q_reg <= quo_q[13:0];
                  div_start_reg <= ema_enable && !ema_fresh_reg;
                  state_reg <= (ema_enable && !ema_fresh_reg) ? SCA_REMA : SCA_EMIT;
               end
            end
            SCA_REMA: begin
               if (div_done_q) begin
                  res_i_reg <= ema_i;
                  res_q_reg <= ema_q;
                  state_reg <= SCA_EMIT;
               end
            end
            SCA_EMIT: begin
               if (emit_go) begin
                  rd_reg <= rd_reg + 17'h00001;
                  if (!rd_last) begin
                     div_start_reg <= 1'b1;
                     state_reg <= SCA_RDIV;
                  end else if (single_reg || !run) begin
                     state_reg <= SCA_IDLE;
                  end else begin
                     seg_idx_reg <= '0;
                     avg_idx_reg <= '0;
                     base_reg <= '0;
                     state_reg <= SCA_ARM;
                  end
               end
            end
            default: begin
               state_reg <= SCA_IDLE;
            end
         endcase
      end
   end
endmodule

//--- shared/sca_pkg.sv
package sca_pkg;
   localparam int SCA_SW = 14;
   localparam int SCA_AW = 16;
   localparam int SCA_MEM_WORDS = 65536;
   localparam int SCA_SUM_W = 31;
   localparam int SCA_FIFO_W = 29;
   localparam int SCA_FIFO_DEPTH = 4;
   localparam logic [16:0] SCA_CAP_1 = 17'h10000;
   localparam logic [16:0] SCA_CAP_2 = 17'h08000;
   localparam logic [16:0] SCA_CAP_4 = 17'h04000;
   localparam logic [16:0] SCA_LEN_MIN = 17'h00010;
   localparam logic [16:0] SCA_LEN_MASK = 17'h1fff0;
   localparam logic [10:0] SCA_SEG_MAX = 11'h400;
   localparam logic [16:0] SCA_AVG_MAX = 17'h10000;
   localparam longint SCA_CLK_HZ = 50000000;
   localparam longint SCA_SAMPLE_HZ = 2000000000;
   localparam longint SCA_DUR_RES_NS = 8;
   localparam int SCA_SA_PER_RES = int'(SCA_SAMPLE_HZ * SCA_DUR_RES_NS / 64'd1000000000);
   localparam longint SCA_AUTO_MS = 200;
   localparam int SCA_AUTO_CYC = int'(SCA_CLK_HZ / 1000 * SCA_AUTO_MS);
   typedef enum logic [2:0] {
      SCA_IDLE = 3'h0,
      SCA_ARM = 3'h1,
      SCA_CAPT = 3'h3,
      SCA_ACCUM = 3'h2,
      SCA_NEXT = 3'h6,
      SCA_RDIV = 3'h7,
      SCA_REMA = 3'h5,
      SCA_EMIT = 3'h4
   } sca_state_type;
endpackage

//--- logic/sca_fifo.sv
`timescale 1ns/10ps
module sca_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 4
) (
   input wire logic clock,
   input wire logic nrst,
   input wire logic s_valid,
   output logic s_ready,
   input wire logic [WIDTH-1:0] s_data,
   output logic m_valid,
   input wire logic m_ready,
   output logic [WIDTH-1:0] m_data
);
   localparam int CW = $clog2(DEPTH + 1);
   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [CW-1:0] cnt_reg;
   logic full_reg;
   logic valid_reg;
   wire push = s_valid & s_ready;
   wire pop = valid_reg & m_ready;
   wire [CW-1:0] cnt_next = cnt_reg + CW'(push) - CW'(pop);
   assign s_ready = !full_reg;
   assign m_valid = valid_reg;
   // Head always sits in entry 0, so the read port is a plain flop
   assign m_data = mem_reg[0];
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         cnt_reg <= '0;
         full_reg <= 1'b0;
         valid_reg <= 1'b0;
      end else begin
         cnt_reg <= cnt_next;
         full_reg <= cnt_next == CW'(DEPTH);
         valid_reg <= cnt_next != '0;
      end
   end
   for (genvar e = 0; e < DEPTH; e++) begin : g_entry
      wire [WIDTH-1:0] above;
      if (e == DEPTH - 1) begin : g_top
         assign above = mem_reg[e];
      end else begin : g_mid
         assign above = mem_reg[e+1];
      end
      wire load_pop = push && (CW'(e + 1) == cnt_reg);
      wire load_push = push && (CW'(e) == cnt_reg);
      always_ff @(posedge clock or negedge nrst) begin
         if (!nrst) begin
            mem_reg[e] <= '0;
         end else if (pop) begin
            mem_reg[e] <= load_pop ? s_data : above;
         end else if (load_push) begin
            mem_reg[e] <= s_data;
         end
      end
   end
endmodule

//--- logic/sca_div.sv
`timescale 1ns/10ps
module sca_div #(
   parameter int NW = 31,
   parameter int DW = 17
) (
   input wire logic clock,
   input wire logic nrst,
   input wire logic start,
   input wire logic [NW-1:0] num,
   input wire logic [DW-1:0] den,
   output logic [NW-1:0] quo,
   output logic done
);
   // Restoring divider, one quotient bit per cycle, truncates toward zero
   logic [NW-1:0] mag_reg;
   logic [NW-1:0] q_reg;
   logic [DW:0] rem_reg;
   logic [DW-1:0] den_reg;
   logic [5:0] cnt_reg;
   logic neg_reg;
   logic done_reg;
   wire [NW-1:0] num_mag = num[NW-1] ? NW'(-num) : num;
   wire [DW:0] trial = {rem_reg[DW-1:0], mag_reg[NW-1]};
   wire fits = trial >= {1'b0, den_reg};
   assign quo = neg_reg ? NW'(-q_reg) : q_reg;
   assign done = done_reg;
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         mag_reg <= '0;
         q_reg <= '0;
         rem_reg <= '0;
         den_reg <= '0;
         cnt_reg <= '0;
         neg_reg <= 1'b0;
         done_reg <= 1'b0;
      end else begin
         done_reg <= cnt_reg == 6'h01;
         if (start) begin
            mag_reg <= num_mag;
            rem_reg <= '0;
            den_reg <= den;
            neg_reg <= num[NW-1];
            cnt_reg <= 6'(NW);
         end else if (cnt_reg != '0) begin
            rem_reg <= fits ? trial - {1'b0, den_reg} : trial;
            mag_reg <= {mag_reg[NW-2:0], 1'b0};
            q_reg <= {q_reg[NW-2:0], fits};
            cnt_reg <= cnt_reg - 6'h01;
         end
      end
   end
endmodule

//--- dv/sca_top_properties.sv
`timescale 1ns/10ps
module sca_top_properties (
   input wire logic clock,
   input wire logic nrst,
   input wire logic [3:0] low_frequency_input_path,
   input wire logic [1:0] chan_select,
   input wire logic run,
   input wire logic single_cmd,
   input wire logic ema_enable,
   input wire logic out_ready,
   input wire logic out_valid,
   input wire logic [13:0] out_i,
   input wire logic [13:0] out_q,
   input wire logic out_last,
   input wire logic busy,
   input wire logic shot_captured,
   input wire logic shot_invalid,
   input wire logic config_error
);
   logic lf_sel;
   logic clean_reg;
   logic clean_next;
   // Armed only from an empty idle state, so stale words never count
   assign lf_sel = low_frequency_input_path[chan_select] && !ema_enable;
   assign clean_next = lf_sel && (clean_reg || (!busy && !out_valid));
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         clean_reg <= 1'b0;
      end else begin
         clean_reg <= clean_next;
      end
   end
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!nrst);
   sequence s_refused;
      !busy ##1 !busy;
   endsequence
   sequence s_quiet;
      !busy [*3];
   endsequence
   sequence s_held;
      out_valid && $stable(out_i) && $stable(out_q) && $stable(out_last);
   endsequence
   AST_BUSY_START: assert property (
      $rose(busy) |-> $past(single_cmd || run, 2)) else $error("busy rose without start");
   AST_OUT_HOLD: assert property (
      out_valid && !out_ready |=> s_held) else $error("stalled word changed");
   AST_INVALID_EXCL: assert property (
      shot_invalid |-> !shot_captured) else $error("invalid shot also accepted");
   AST_CFG_REFUSED: assert property (
      $rose(config_error) |-> s_refused) else $error("refused start went busy");
   AST_LF_ZERO: assert property (
      clean_reg && lf_sel && out_valid |-> out_q == 14'h0000) else $error("q not zero");
   AST_CAPT_BUSY: assert property (
      shot_captured || shot_invalid |-> busy) else $error("shot while idle");
   AST_CAPT_GAP: assert property (
      shot_captured |=> !shot_captured [*8]) else $error("shots too close");
   AST_QUIET_IDLE: assert property (
      s_quiet |-> !shot_captured && !shot_invalid) else $error("shot outside arm");
endmodule

bind sca_top sca_top_properties sca_top_properties_inst (
   .clock(clock), .nrst(nrst), .low_frequency_input_path(low_frequency_input_path),
   .chan_select(chan_select), .run(run), .single_cmd(single_cmd), .ema_enable(ema_enable),
   .out_ready(out_ready), .out_valid(out_valid), .out_i(out_i), .out_q(out_q),
   .out_last(out_last), .busy(busy), .shot_captured(shot_captured),
   .shot_invalid(shot_invalid), .config_error(config_error)
);

//--- dv/sca_ddc_model.sv
`timescale 1ns/10ps
module sca_ddc_model (
   input wire logic clock,
   input wire logic nrst,
   input wire logic [3:0][13:0] lvl_i,
   input wire logic [3:0][13:0] lvl_q,
   input wire logic slow,
   input wire logic loss_req,
   output logic [3:0][13:0] sig_i,
   output logic [3:0][13:0] sig_q,
   output logic sig_valid,
   output logic sig_loss
);
   logic phase_reg;
   logic valid_next;
   assign valid_next = !slow || !phase_reg;
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         phase_reg <= 1'b0;
         sig_valid <= 1'b0;
         sig_i <= '0;
         sig_q <= '0;
         sig_loss <= 1'b0;
      end else begin
         phase_reg <= !phase_reg;
         sig_valid <= valid_next;
         // Off-slot values inverted so stray sampling shows up
         sig_i <= valid_next ? lvl_i : ~lvl_i;
         sig_q <= valid_next ? lvl_q : ~lvl_q;
         sig_loss <= loss_req;
      end
   end
endmodule

//--- dv/testbench.sv
`timescale 1ns/10ps
module testbench;
   logic clock, nrst, sig_valid, sig_loss, slow, loss_req, run, single_cmd, trig_enable;
   logic trig_pin, len_is_duration, seg_enable, hw_avg_enable, ema_enable, ema_reset;
   logic out_ready, out_valid, out_last, busy, shot_captured, shot_invalid, config_error;
   logic [3:0][13:0] sig_i, sig_q, lvl_i, lvl_q;
   logic [3:0] lf;
   logic [1:0] chan_select;
   logic [2:0] chan_active;
   logic [16:0] len_samples, avg_count;
   logic [12:0] dur_units;
   logic [10:0] seg_count;
   logic [15:0] ema_count;
   logic [13:0] out_i, out_q;
   logic [13:0] wi[$];
   logic [13:0] wq[$];
   logic wl[$];
   int err_count = 0;
   int n_compared = 0;
   int cycles = 0;
   int n_shots = 0;
   int n_bad = 0;
   sca_ddc_model sca_ddc_model_inst (.clock(clock), .nrst(nrst), .lvl_i(lvl_i), .lvl_q(lvl_q),
      .slow(slow), .loss_req(loss_req), .sig_i(sig_i), .sig_q(sig_q), .sig_valid(sig_valid),
      .sig_loss(sig_loss));
   sca_top #(.AUTO_CYC(50)) sca_top_inst (.clock(clock), .nrst(nrst), .sig_i(sig_i),
      .sig_q(sig_q), .sig_valid(sig_valid), .sig_loss(sig_loss),
      .low_frequency_input_path(lf), .chan_select(chan_select), .chan_active(chan_active),
      .run(run), .single_cmd(single_cmd), .trig_enable(trig_enable), .trig_pin(trig_pin),
      .len_is_duration(len_is_duration), .len_samples(len_samples), .dur_units(dur_units),
      .seg_enable(seg_enable), .seg_count(seg_count), .hw_avg_enable(hw_avg_enable),
      .avg_count(avg_count), .ema_enable(ema_enable), .ema_count(ema_count),
      .ema_reset(ema_reset), .out_ready(out_ready), .out_valid(out_valid), .out_i(out_i),
      .out_q(out_q), .out_last(out_last), .busy(busy), .shot_captured(shot_captured),
      .shot_invalid(shot_invalid), .config_error(config_error));
   initial begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end
   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (shot_captured === 1'b1) n_shots <= n_shots + 1;
      if (shot_invalid === 1'b1) n_bad <= n_bad + 1;
   end
   always @(negedge clock) begin
      if (cycles == 60000) begin
         err_count++;
         stop_test();
      end
   end
   task automatic stop_test();
      $display("compared=%0d mismatches=%0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [16:0] got, input logic [16:0] exp);
      n_compared++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Long stall at the start fills the FIFO and holds the readout back
   task automatic collect(input int n, input bit stall);
      int t;
      t = 0;
      wi.delete();
      wq.delete();
      wl.delete();
      while (wi.size() < n && t < 20000) begin
         @(negedge clock);
         t++;
         // Ready set first so a word is logged only if the next edge pops it
         out_ready = !(stall && t < 300);
         if (out_valid === 1'b1 && out_ready === 1'b1) begin
            wi.push_back(out_i);
            wq.push_back(out_q);
            wl.push_back(out_last);
         end
      end
      chk(17'(wi.size()), 17'(n));
   endtask
   task automatic verify(input int n, input int sp, input logic [13:0] ai, aq, bi, bq);
      for (int k = 0; k < wi.size(); k++) begin
         chk(17'(wi[k]), 17'(k < sp ? ai : bi));
         chk(17'(wq[k]), 17'(k < sp ? aq : bq));
         chk(17'(wl[k]), 17'(k == n - 1));
      end
   endtask
   task automatic wait_idle();
      int t;
      t = 0;
      while (busy !== 1'b0 && t < 5000) begin
         @(negedge clock);
         t++;
      end
      repeat (5) @(negedge clock);
      chk(17'(busy), 17'h0);
      chk(17'(out_valid), 17'h0);
   endtask
   task automatic single_run(input int n, input logic [13:0] ei, eq);
      int s0;
      s0 = n_shots;
      single_cmd = 1'b1;
      @(negedge clock);
      single_cmd = 1'b0;
      collect(n, 1'b0);
      verify(n, n, ei, eq, ei, eq);
      wait_idle();
      repeat (120) @(negedge clock);
      chk(17'(n_shots - s0), 17'h1);
      chk(17'(config_error), 17'h0);
   endtask
   task automatic shoot(input bit bad);
      int t;
      int c0;
      int b0;
      t = 0;
      c0 = n_shots;
      b0 = n_bad;
      trig_pin = 1'b1;
      repeat (4) @(negedge clock);
      trig_pin = 1'b0;
      while (n_shots == c0 && n_bad == b0 && t < 2000) begin
         @(negedge clock);
         t++;
      end
      chk(17'(n_bad - b0), 17'(bad));
      chk(17'(n_shots - c0), 17'(!bad));
   endtask
   initial begin
      {nrst, slow, loss_req, run, single_cmd, trig_enable, trig_pin} = '0;
      {len_is_duration, seg_enable, hw_avg_enable, ema_enable, ema_reset} = '0;
      {lf, chan_select, dur_units, seg_count, avg_count, ema_count} = '0;
      out_ready = 1'b1;
      chan_active = 3'h4;
      len_samples = 17'h08000;
      for (int k = 0; k < 4; k++) begin
         lvl_i[k] = 14'(16 * (k + 1));
         lvl_q[k] = 14'(-16 * (k + 1));
      end
      repeat (10) @(negedge clock);
      nrst = 1'b1;
      @(negedge clock);
      single_cmd = 1'b1;
      @(negedge clock);
      single_cmd = 1'b0;
      repeat (3) @(negedge clock);
      chk(17'(config_error), 17'h1);
      chk(17'(busy), 17'h0);
      {seg_enable, seg_count, len_samples, chan_active} = {1'b1, 11'h400, 17'h00020, 3'h3};
      // Single always records one segment, so segment refusal needs run
      run = 1'b1;
      @(negedge clock);
      run = 1'b0;
      repeat (3) @(negedge clock);
      chk(17'(config_error), 17'h1);
      {seg_enable, seg_count, len_samples, chan_active} = {1'b0, 11'h000, 17'h00010, 3'h1};
      $display("test refusal done");
      lf = 4'h8;
      for (int s = 0; s < 4; s++) begin
         chan_select = 2'(s);
         single_run(16, lvl_i[s], s == 3 ? 14'h0 : lvl_q[s]);
      end
      {lf, chan_select, len_samples} = {4'h0, 2'h0, 17'h00005};
      single_run(16, 14'h0010, 14'h3ff0);
      len_samples = 17'h0002f;
      single_run(32, 14'h0010, 14'h3ff0);
      {len_is_duration, dur_units} = {1'b1, 13'h0002};
      single_run(32, 14'h0010, 14'h3ff0);
      {len_is_duration, len_samples} = {1'b0, 17'h00010};
      $display("test length done");
      {hw_avg_enable, avg_count, trig_enable, run} = {1'b1, 17'h00002, 1'b1, 1'b1};
      {lvl_i[0], lvl_q[0]} = {14'h0064, 14'h3fce};
      repeat (5) @(negedge clock);
      shoot(1'b0);
      {lvl_i[0], loss_req} = {14'h1fff, 1'b1};
      shoot(1'b1);
      {lvl_i[0], lvl_q[0], loss_req} = {14'h012d, 14'h3f9b, 1'b0};
      chk(17'(out_valid), 17'h0);
      shoot(1'b0);
      run = 1'b0;
      collect(16, 1'b1);
      verify(16, 16, 14'h00c8, 14'h3fb5, 14'h0, 14'h0);
      wait_idle();
      $display("test averaging done");
      {hw_avg_enable, seg_enable, seg_count, slow, run} = {1'b0, 1'b1, 11'h002, 1'b1, 1'b1};
      repeat (5) @(negedge clock);
      shoot(1'b0);
      {lvl_i[0], lvl_q[0]} = {14'h0100, 14'h3f00};
      shoot(1'b0);
      run = 1'b0;
      collect(32, 1'b0);
      verify(32, 16, 14'h012d, 14'h3f9b, 14'h0100, 14'h3f00);
      wait_idle();
      $display("test segments done");
      {seg_enable, slow, trig_enable, ema_enable, ema_count} = {3'h0, 1'b1, 16'h0002};
      {lvl_i[0], lvl_q[0], ema_reset} = {14'h0064, 14'h0000, 1'b1};
      @(negedge clock);
      ema_reset = 1'b0;
      single_run(16, 14'h0064, 14'h0000);
      {lvl_i[0], lvl_q[0]} = {14'h00c8, 14'h3f9c};
      single_run(16, 14'h0096, 14'h3fce);
      $display("test moving average done");
      stop_test();
   end
endmodule
